// >>> common/dtc_regs.vh
// Register map, field positions and reset values of the dual timer/counter block.
// Offsets are register indices; each register takes one aligned word, so its byte address is four times the index.
`ifndef DTC_REGS_VH
`define DTC_REGS_VH

`define DTC_OFF_CONTROL 10'h088
`define DTC_OFF_MODE 10'h089
`define DTC_OFF_A_LOWER 10'h08a
`define DTC_OFF_B_LOWER 10'h08b
`define DTC_OFF_A_UPPER 10'h08c
`define DTC_OFF_B_UPPER 10'h08d
`define DTC_OFF_CONFIG_B 10'h091
`define DTC_OFF_A_RELOAD_LOWER 10'h092
`define DTC_OFF_B_RELOAD_LOWER 10'h093
`define DTC_OFF_A_RELOAD_UPPER 10'h094
`define DTC_OFF_B_RELOAD_UPPER 10'h095

`define DTC_CTL_B_OVF 7
`define DTC_CTL_B_RUN 6
`define DTC_CTL_A_OVF 5
`define DTC_CTL_A_RUN 4
`define DTC_CTL_B_REQ 3
`define DTC_CTL_B_EDGE 2
`define DTC_CTL_A_REQ 1
`define DTC_CTL_A_EDGE 0

`define DTC_MODE_B_QUAL 7
`define DTC_MODE_B_SRC 6
`define DTC_MODE_A_QUAL 3
`define DTC_MODE_A_SRC 2

`define DTC_MODE_VAR 2'b00
`define DTC_MODE_RELOAD16 2'b01
`define DTC_MODE_RELOAD8 2'b10
`define DTC_MODE_SPLIT 2'b11

`define DTC_CONTROL_RST 8'h00
`define DTC_MODE_RST 8'h00
`define DTC_CONFIG_B_RST 8'h24
`define DTC_RELOAD_RST 8'h00

`endif

// >>> rtl/dtc_pin_edge.v
// Pin sampler: registers a synchronous pin once per clock and flags a high-to-low step.
// Assumes the pin is already synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module dtc_pin_edge (
    input wire pclk,
    input wire presetn,
    input wire pin,
    output reg sample_r,
    output wire fall
);
    // Reset to high, so a pin held low at release is taken as a falling edge in the first cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_r <= 1'b1;
        end else begin
            sample_r <= pin;
        end
    end

    assign fall = sample_r & ~pin;
endmodule
`default_nettype wire

// >>> rtl/dtc_counter.v
// One 16-bit timer/counter datapath: upper and lower bytes, modes 0 to 2, split lower half of mode 3.
// Assumes the top resolves run, gating and software writes; the upper byte of split mode lives in the top.
`timescale 1ns/1ps
`include "dtc_regs.vh"
`default_nettype none
module dtc_counter (
    input wire [1:0] mode,
    input wire [2:0] pwidth,
    input wire tick,
    input wire [7:0] lower,
    input wire [7:0] upper,
    input wire [7:0] rld_lower,
    input wire [7:0] rld_upper,
    output reg [7:0] lower_nxt,
    output reg [7:0] upper_nxt,
    output reg ovf
);
    reg [7:0] pmask;
    reg [8:0] lsum;
    reg [8:0] usum;

    always @* begin
        pmask = 8'hff >> (3'd7 - pwidth);
        lsum = {1'b0, lower} + 9'h001;
        usum = {1'b0, upper} + 9'h001;
        lower_nxt = lower;
        upper_nxt = upper;
        ovf = 1'b0;
        if (tick) begin
            case (mode)
                `DTC_MODE_VAR: begin
                    // Unused prescaler bits are left as they were; software must ignore them
                    lower_nxt = (lower & ~pmask) | (lsum[7:0] & pmask);
                    if ((lower & pmask) == pmask) begin
                        upper_nxt = usum[7:0];
                        ovf = usum[8];
                    end
                end
                `DTC_MODE_RELOAD16: begin
                    lower_nxt = lsum[7:0];
                    if (lsum[8]) begin
                        upper_nxt = usum[7:0];
                        if (usum[8]) begin
                            lower_nxt = rld_lower;
                            upper_nxt = rld_upper;
                            ovf = 1'b1;
                        end
                    end
                end
                `DTC_MODE_RELOAD8: begin
                    lower_nxt = lsum[8] ? upper : lsum[7:0];
                    ovf = lsum[8];
                end
                default: begin
                    lower_nxt = lsum[7:0];
                    ovf = lsum[8];
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// >>> rtl/dtc_top.v
// Dual timer/counter with control, mode, count, prescale and reload registers on APB.
// Assumes synchronous pins and a processor that pulses the vector acknowledges.
//
// Behaviour
// - Mode 0 is upper byte behind prescaler
// - Reset prescaler gives 13-bit mode 0
// - Mode 0 rollover sets overflow flag
// - Count when run and gate pin permits
// - Mode 0 unused lower bits are indeterminate
// - Run bit never alters the count
// - Gate bits at mode bits 7, 3
// - Mode 1 counts 16 bits, reloads, flags
// - Reload registers reset to zero
// - Mode 2 reloads lower from upper byte
// - Counter B in mode 3 holds
// - A mode 3 lower byte uses A controls
// - A mode 3 upper byte uses B controls
// - B mode 3 toggles stop, overflow stays
// - Control bits 7..4 overflow and run
// - Vector acknowledge clears overflow flag
// - Edge mode sets request on falling edge
// - Level mode request follows inverted pin
// - Control bits 3..0 request and edge
// - Mode register fields for B and A
// - Source bit picks clock or pin
// - Mode bits select four operating modes
// - Timer counts once per clock
// - Counter counts sampled high-to-low steps
// - Prescale field plus one, resets 100
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "dtc_regs.vh"
`default_nettype none
module dtc_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire count_pin_a,
    input wire count_pin_b,
    input wire extpin_a,
    input wire extpin_b,
    input wire ctr_a_vector_ack,
    input wire ctr_b_vector_ack,
    input wire extreq_a_vector_ack,
    input wire extreq_b_vector_ack,
    output reg ctr_a_overflow_flag,
    output reg ctr_b_overflow_flag,
    output reg extreq_a_flag,
    output reg extreq_b_flag,
    output reg ctr_b_overflow_pulse
);
    reg [7:0] control_r;
    reg [7:0] mode_r;
    reg [7:0] config_b_r;
    reg [7:0] ctr_a_lower_r;
    reg [7:0] ctr_a_upper_r;
    reg [7:0] ctr_b_lower_r;
    reg [7:0] ctr_b_upper_r;
    reg [7:0] ctr_a_reload_lower_r;
    reg [7:0] ctr_a_reload_upper_r;
    reg [7:0] ctr_b_reload_lower_r;
    reg [7:0] ctr_b_reload_upper_r;

    wire cnt_a_fall;
    wire cnt_b_fall;
    wire ext_a_smp;
    wire ext_a_fall;
    wire ext_b_smp;
    wire ext_b_fall;

    dtc_pin_edge u_cnt_a (.pclk(pclk), .presetn(presetn), .pin(count_pin_a), .sample_r(), .fall(cnt_a_fall));
    dtc_pin_edge u_cnt_b (.pclk(pclk), .presetn(presetn), .pin(count_pin_b), .sample_r(), .fall(cnt_b_fall));
    dtc_pin_edge u_ext_a (.pclk(pclk), .presetn(presetn), .pin(extpin_a), .sample_r(ext_a_smp), .fall(ext_a_fall));
    dtc_pin_edge u_ext_b (.pclk(pclk), .presetn(presetn), .pin(extpin_b), .sample_r(ext_b_smp), .fall(ext_b_fall));

    wire [1:0] mode_a = mode_r[1:0];
    wire [1:0] mode_b = mode_r[5:4];
    wire ctr_a_run = control_r[`DTC_CTL_A_RUN];
    wire ctr_b_run = control_r[`DTC_CTL_B_RUN];
    wire split_a = (mode_a == `DTC_MODE_SPLIT);

    // Gate uses the sampled pin level, source picks clock or sampled falling edge
    wire gate_a = ctr_a_run & (~mode_r[`DTC_MODE_A_QUAL] | ext_a_smp);
    wire gate_b = ctr_b_run & (~mode_r[`DTC_MODE_B_QUAL] | ext_b_smp);
    wire src_a = mode_r[`DTC_MODE_A_SRC] ? cnt_a_fall : 1'b1;
    wire src_b = mode_r[`DTC_MODE_B_SRC] ? cnt_b_fall : 1'b1;
    wire tick_a = gate_a & src_a;
    // B holds in its own mode 3 exactly as with run cleared; leaving mode 3 restarts it
    wire tick_b = gate_b & src_b & (mode_b != `DTC_MODE_SPLIT);

    wire [7:0] a_lower_nxt;
    wire [7:0] a_upper_nxt;
    wire a_ovf;
    wire [7:0] b_lower_nxt;
    wire [7:0] b_upper_nxt;
    wire b_ovf;

    dtc_counter u_ctr_a (
        .mode(mode_a),
        .pwidth(config_b_r[2:0]),
        .tick(tick_a),
        .lower(ctr_a_lower_r),
        .upper(ctr_a_upper_r),
        .rld_lower(ctr_a_reload_lower_r),
        .rld_upper(ctr_a_reload_upper_r),
        .lower_nxt(a_lower_nxt),
        .upper_nxt(a_upper_nxt),
        .ovf(a_ovf)
    );

    dtc_counter u_ctr_b (
        .mode(mode_b),
        .pwidth(config_b_r[5:3]),
        .tick(tick_b),
        .lower(ctr_b_lower_r),
        .upper(ctr_b_upper_r),
        .rld_lower(ctr_b_reload_lower_r),
        .rld_upper(ctr_b_reload_upper_r),
        .lower_nxt(b_lower_nxt),
        .upper_nxt(b_upper_nxt),
        .ovf(b_ovf)
    );

    // Split upper byte of A counts clocks under B's run bit only, no gate
    wire ah_tick = split_a & ctr_b_run;
    wire [8:0] ah_sum = {1'b0, ctr_a_upper_r} + 9'h001;
    wire ah_ovf = ah_tick & ah_sum[8];
    wire [7:0] a_upper_eff = split_a ? (ah_tick ? ah_sum[7:0] : ctr_a_upper_r) : a_upper_nxt;

    wire set_a_ovf = a_ovf;
    wire set_b_ovf = ah_ovf | b_ovf;

    // APB decode; zero wait states. One register per word; a misaligned address decodes as unmapped
    wire [9:0] pidx = (paddr[1:0] == 2'b00) ? paddr[11:2] : 10'h3ff;
    wire wr = psel & penable & pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire wr_ctl = wr & (pidx == `DTC_OFF_CONTROL);

    function hit_known;
        input [9:0] a;
        begin
            case (a)
                `DTC_OFF_CONTROL, `DTC_OFF_MODE, `DTC_OFF_A_LOWER, `DTC_OFF_B_LOWER,
                `DTC_OFF_A_UPPER, `DTC_OFF_B_UPPER, `DTC_OFF_CONFIG_B,
                `DTC_OFF_A_RELOAD_LOWER, `DTC_OFF_B_RELOAD_LOWER,
                `DTC_OFF_A_RELOAD_UPPER, `DTC_OFF_B_RELOAD_UPPER: hit_known = 1'b1;
                default: hit_known = 1'b0;
            endcase
        end
    endfunction

    // Software value of a flag, then acknowledge clear, then hardware set wins
    function flag_next;
        input cur;
        input swr;
        input swv;
        input ack;
        input hwset;
        reg v;
        begin
            v = swr ? swv : cur;
            if (ack) begin
                v = 1'b0;
            end
            flag_next = v | hwset;
        end
    endfunction

    reg [7:0] control_nxt;
    reg [7:0] rd_nxt;

    always @* begin
        control_nxt = control_r;
        if (wr_ctl) begin
            control_nxt = pwdata[7:0];
        end
        control_nxt[`DTC_CTL_A_OVF] = flag_next(control_r[`DTC_CTL_A_OVF], wr_ctl, pwdata[`DTC_CTL_A_OVF],
                                                ctr_a_vector_ack, set_a_ovf);
        control_nxt[`DTC_CTL_B_OVF] = flag_next(control_r[`DTC_CTL_B_OVF], wr_ctl, pwdata[`DTC_CTL_B_OVF],
                                                ctr_b_vector_ack, set_b_ovf);
        // Edge mode: sticky, ack clears; level mode: flag mirrors inverted pin
        if (control_nxt[`DTC_CTL_A_EDGE]) begin
            control_nxt[`DTC_CTL_A_REQ] = flag_next(control_r[`DTC_CTL_A_REQ], wr_ctl, pwdata[`DTC_CTL_A_REQ],
                                                    extreq_a_vector_ack, ext_a_fall);
        end else begin
            control_nxt[`DTC_CTL_A_REQ] = ~extpin_a;
        end
        if (control_nxt[`DTC_CTL_B_EDGE]) begin
            control_nxt[`DTC_CTL_B_REQ] = flag_next(control_r[`DTC_CTL_B_REQ], wr_ctl, pwdata[`DTC_CTL_B_REQ],
                                                    extreq_b_vector_ack, ext_b_fall);
        end else begin
            control_nxt[`DTC_CTL_B_REQ] = ~extpin_b;
        end
    end

    always @* begin
        case (pidx)
            `DTC_OFF_CONTROL: rd_nxt = control_r;
            `DTC_OFF_MODE: rd_nxt = mode_r;
            `DTC_OFF_A_LOWER: rd_nxt = ctr_a_lower_r;
            `DTC_OFF_B_LOWER: rd_nxt = ctr_b_lower_r;
            `DTC_OFF_A_UPPER: rd_nxt = ctr_a_upper_r;
            `DTC_OFF_B_UPPER: rd_nxt = ctr_b_upper_r;
            `DTC_OFF_CONFIG_B: rd_nxt = config_b_r;
            `DTC_OFF_A_RELOAD_LOWER: rd_nxt = ctr_a_reload_lower_r;
            `DTC_OFF_B_RELOAD_LOWER: rd_nxt = ctr_b_reload_lower_r;
            `DTC_OFF_A_RELOAD_UPPER: rd_nxt = ctr_a_reload_upper_r;
            `DTC_OFF_B_RELOAD_UPPER: rd_nxt = ctr_b_reload_upper_r;
            default: rd_nxt = 8'h00;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_r <= `DTC_CONTROL_RST;
            mode_r <= `DTC_MODE_RST;
            config_b_r <= `DTC_CONFIG_B_RST;
            ctr_a_lower_r <= 8'h00;
            ctr_a_upper_r <= 8'h00;
            ctr_b_lower_r <= 8'h00;
            ctr_b_upper_r <= 8'h00;
            ctr_a_reload_lower_r <= `DTC_RELOAD_RST;
            ctr_a_reload_upper_r <= `DTC_RELOAD_RST;
            ctr_b_reload_lower_r <= `DTC_RELOAD_RST;
            ctr_b_reload_upper_r <= `DTC_RELOAD_RST;
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctr_a_overflow_flag <= 1'b0;
            ctr_b_overflow_flag <= 1'b0;
            extreq_a_flag <= 1'b0;
            extreq_b_flag <= 1'b0;
            ctr_b_overflow_pulse <= 1'b0;
        end else begin
            control_r <= control_nxt;
            ctr_a_overflow_flag <= control_nxt[`DTC_CTL_A_OVF];
            ctr_b_overflow_flag <= control_nxt[`DTC_CTL_B_OVF];
            extreq_a_flag <= control_nxt[`DTC_CTL_A_REQ];
            extreq_b_flag <= control_nxt[`DTC_CTL_B_REQ];
            // B's own overflow, usable as a baud tick even without its flag
            ctr_b_overflow_pulse <= b_ovf;
            // Count updates run freely; the run bit only gates ticks
            // A software write to a count byte wins over the tick in that cycle
            ctr_a_lower_r <= (wr && pidx == `DTC_OFF_A_LOWER) ? pwdata[7:0] : a_lower_nxt;
            ctr_a_upper_r <= (wr && pidx == `DTC_OFF_A_UPPER) ? pwdata[7:0] : a_upper_eff;
            ctr_b_lower_r <= (wr && pidx == `DTC_OFF_B_LOWER) ? pwdata[7:0] : b_lower_nxt;
            ctr_b_upper_r <= (wr && pidx == `DTC_OFF_B_UPPER) ? pwdata[7:0] : b_upper_nxt;
            if (wr && pidx == `DTC_OFF_MODE) begin
                mode_r <= pwdata[7:0];
            end
            if (wr && pidx == `DTC_OFF_CONFIG_B) begin
                config_b_r <= pwdata[7:0];
            end
            if (wr && pidx == `DTC_OFF_A_RELOAD_LOWER) begin
                ctr_a_reload_lower_r <= pwdata[7:0];
            end
            if (wr && pidx == `DTC_OFF_B_RELOAD_LOWER) begin
                ctr_b_reload_lower_r <= pwdata[7:0];
            end
            if (wr && pidx == `DTC_OFF_A_RELOAD_UPPER) begin
                ctr_a_reload_upper_r <= pwdata[7:0];
            end
            if (wr && pidx == `DTC_OFF_B_RELOAD_UPPER) begin
                ctr_b_reload_upper_r <= pwdata[7:0];
            end
            // Ready is raised in the setup cycle so the access phase completes at once
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_known(pidx);
            if (rd_setup) begin
                prdata <= {24'h000000, rd_nxt};
            end
        end
    end
endmodule
`default_nettype wire

// >>> testbench/dtc_pins_model.sv
// Pin model: external count and request pins, moved just after clock edges.
// Assumes the bench drives it through its tasks.
`timescale 1ns/1ps
`default_nettype none
module dtc_pins_model (
    input wire logic pclk,
    output var logic count_pin_a,
    output var logic count_pin_b,
    output var logic extpin_a,
    output var logic extpin_b
);
    initial begin
        count_pin_a = 1'b1;
        count_pin_b = 1'b1;
        extpin_a = 1'b1;
        extpin_b = 1'b1;
    end
    // Low stands two cycles and high at least two, so the device samples each level at least once
    task automatic falls(input int n);
        repeat (n) begin
            @(posedge pclk);
            count_pin_a <= 1'b0;
            repeat (2) @(posedge pclk);
            count_pin_a <= 1'b1;
            repeat (2) @(posedge pclk);
        end
    endtask
    task automatic ext(input logic a, input logic b);
        @(posedge pclk);
        extpin_a <= a;
        extpin_b <= b;
    endtask
endmodule
`default_nettype wire

// >>> testbench/dtc_top_asserts.sv
// Checker for request flags, overflow flags and vector acknowledges.
// Assumes control is written only over APB.
`timescale 1ns/1ps
`include "dtc_regs.vh"
`default_nettype none
module dtc_top_asserts (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire extpin_a,
    input wire extpin_b,
    input wire ctr_a_vector_ack,
    input wire ctr_b_vector_ack,
    input wire extreq_a_vector_ack,
    input wire ctr_a_overflow_flag,
    input wire ctr_b_overflow_flag,
    input wire extreq_a_flag,
    input wire extreq_b_flag,
    input wire ctr_b_overflow_pulse
);
    wire wr_ctl = psel && penable && pwrite && paddr == {`DTC_OFF_CONTROL, 2'b00};
    logic edge_a_r;
    logic edge_b_r;
    logic run_a_r;
    // Software-only bits, shadowed so the flag checks know the mode
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_a_r <= 1'b0;
            edge_b_r <= 1'b0;
            run_a_r <= 1'b0;
        end else if (wr_ctl) begin
            edge_a_r <= pwdata[`DTC_CTL_A_EDGE];
            edge_b_r <= pwdata[`DTC_CTL_B_EDGE];
            run_a_r <= pwdata[`DTC_CTL_A_RUN];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_level_req_a: assert property (
        $past(presetn) && !edge_a_r && !$past(edge_a_r) |-> extreq_a_flag == !$past(extpin_a))
        else $error("level request a wrong");
    chk_level_req_b: assert property (
        $past(presetn) && !edge_b_r && !$past(edge_b_r) |-> extreq_b_flag == !$past(extpin_b))
        else $error("level request b wrong");
    chk_edge_set_b: assert property (
        edge_b_r && $past(extpin_b) && !extpin_b |=> extreq_b_flag)
        else $error("falling edge missed");
    chk_edge_cause_b: assert property (
        edge_b_r && $past(edge_b_r) && $rose(extreq_b_flag) && !$past(wr_ctl)
        |-> !$past(extpin_b) && $past(extpin_b, 2))
        else $error("request set without edge");
    chk_ext_ack_a: assert property (
        edge_a_r && extreq_a_vector_ack && extpin_a && !wr_ctl |=> !extreq_a_flag)
        else $error("request ack ignored");
    chk_ovf_ack_a: assert property (
        ctr_a_vector_ack && !run_a_r && !wr_ctl |=> !ctr_a_overflow_flag)
        else $error("overflow ack ignored");
    chk_ovf_hold_b: assert property (
        $fell(ctr_b_overflow_flag) |-> $past(ctr_b_vector_ack) || $past(wr_ctl))
        else $error("overflow flag lost");
    chk_pulse_b: assert property (
        ctr_b_overflow_pulse |-> ctr_b_overflow_flag)
        else $error("overflow pulse without flag");
    cover property (ctr_b_overflow_pulse);
    cover property (edge_b_r && extreq_b_flag);
    cover property (ctr_a_vector_ack && ctr_a_overflow_flag);
endmodule
bind dtc_top dtc_top_asserts i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .extpin_a, .extpin_b, .ctr_a_vector_ack, .ctr_b_vector_ack, .extreq_a_vector_ack,
    .ctr_a_overflow_flag, .ctr_b_overflow_flag, .extreq_a_flag, .extreq_b_flag, .ctr_b_overflow_pulse);
`default_nettype wire

// >>> testbench/dtc_top_tb.sv
// Testbench for the dual timer/counter: APB master, pin model, one task per scenario.
// Assumes pins synchronous to pclk; every transfer waits for pready, only the watchdog ends a wait.
`timescale 1ns/1ps
`include "dtc_regs.vh"
`default_nettype none
module dtc_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] ack = 4'h0;
    wire [31:0] prdata;
    wire pready, pslverr, cpa, cpb, epa, epb, fa, fb, ra, rb, pb;
    logic [7:0] rd;
    logic err;
    int failures = 0;
    int checks = 0;
    int npulse = 0;
    localparam logic [9:0] ADR [8] = '{10'h088, 10'h089, 10'h091, 10'h092, 10'h093, 10'h094, 10'h095, 10'h090};
    localparam logic [7:0] RST [8] = '{8'h00, 8'h00, 8'h24, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    always #25 pclk = ~pclk;
    // Counts counter B's own overflow pulses; each stands one cycle
    always @(posedge pclk) begin
        if (pb === 1'b1) begin
            npulse <= npulse + 1;
        end
    end
    dtc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .count_pin_a(cpa), .count_pin_b(cpb), .extpin_a(epa), .extpin_b(epb),
        .ctr_a_vector_ack(ack[0]), .ctr_b_vector_ack(ack[1]), .extreq_a_vector_ack(ack[2]),
        .extreq_b_vector_ack(ack[3]), .ctr_a_overflow_flag(fa), .ctr_b_overflow_flag(fb),
        .extreq_a_flag(ra), .extreq_b_flag(rb), .ctr_b_overflow_pulse(pb));
    dtc_pins_model i_pins (.pclk(pclk), .count_pin_a(cpa), .count_pin_b(cpb), .extpin_a(epa), .extpin_b(epb));
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {a, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string name, input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(name, rd & m, e);
    endtask
    task automatic pulse_ack(input logic [3:0] v);
        @(posedge pclk);
        ack <= v;
        @(posedge pclk);
        ack <= 4'h0;
        #1;
    endtask
    // Mode write then hold again: exactly three counting clocks
    task automatic run_b(input logic [7:0] m, input logic [7:0] up, input logic [7:0] lo);
        wr(`DTC_OFF_B_UPPER, up);
        wr(`DTC_OFF_B_LOWER, lo);
        wr(`DTC_OFF_MODE, m);
        wr(`DTC_OFF_MODE, 8'h30);
    endtask
    task automatic t_map();
        for (int i = 0; i < 8; i++) begin
            rdchk("reset value", ADR[i], 8'hff, RST[i]);
        end
        chk("slverr", {7'h0, err}, 8'h01);
    endtask
    task automatic t_reload16();
        wr(`DTC_OFF_MODE, 8'h30);
        wr(`DTC_OFF_B_RELOAD_UPPER, 8'h12);
        wr(`DTC_OFF_B_RELOAD_LOWER, 8'h34);
        wr(`DTC_OFF_CONTROL, 8'h40);
        run_b(8'h10, 8'hff, 8'hfe);
        rdchk("b lower", `DTC_OFF_B_LOWER, 8'hff, 8'h35);
        rdchk("b upper", `DTC_OFF_B_UPPER, 8'hff, 8'h12);
        rdchk("mode", `DTC_OFF_MODE, 8'hff, 8'h30);
        rdchk("control", `DTC_OFF_CONTROL, 8'hff, 8'hc0);
        pulse_ack(4'b0010);
        chk("b flag", {7'h0, fb}, 8'h00);
        chk("b pulses", npulse[7:0], 8'h01);
    endtask
    task automatic t_reload8();
        run_b(8'h20, 8'h80, 8'hfe);
        rdchk("b lower", `DTC_OFF_B_LOWER, 8'hff, 8'h81);
        rdchk("b upper", `DTC_OFF_B_UPPER, 8'hff, 8'h80);
        chk("b flag", {7'h0, fb}, 8'h01);
        pulse_ack(4'b0010);
    endtask
    task automatic t_var();
        run_b(8'h00, 8'hff, 8'h1f);
        rdchk("b lower", `DTC_OFF_B_LOWER, 8'h1f, 8'h02);
        rdchk("b upper", `DTC_OFF_B_UPPER, 8'hff, 8'h00);
        rdchk("control", `DTC_OFF_CONTROL, 8'hff, 8'hc0);
        pulse_ack(4'b0010);
        wr(`DTC_OFF_CONFIG_B, 8'h00);
        run_b(8'h00, 8'h10, 8'h01);
        rdchk("b upper", `DTC_OFF_B_UPPER, 8'hff, 8'h12);
        rdchk("b lower", `DTC_OFF_B_LOWER, 8'h01, 8'h00);
    endtask
    task automatic t_split();
        wr(`DTC_OFF_CONTROL, 8'h00);
        wr(`DTC_OFF_MODE, 8'h33);
        wr(`DTC_OFF_A_UPPER, 8'hfe);
        wr(`DTC_OFF_CONTROL, 8'h40);
        @(posedge pclk);
        #1;
        chk("b flag early", {7'h0, fb}, 8'h00);
        @(posedge pclk);
        #1;
        chk("b flag", {7'h0, fb}, 8'h01);
        chk("a flag", {7'h0, fa}, 8'h00);
        chk("b pulses", npulse[7:0], 8'h03);
        wr(`DTC_OFF_CONTROL, 8'h00);
    endtask
    task automatic t_gate();
        wr(`DTC_OFF_MODE, 8'h3e);
        wr(`DTC_OFF_A_UPPER, 8'h00);
        wr(`DTC_OFF_A_LOWER, 8'h00);
        wr(`DTC_OFF_CONTROL, 8'h10);
        i_pins.falls(3);
        i_pins.ext(1'b0, 1'b1);
        i_pins.falls(2);
        i_pins.ext(1'b1, 1'b1);
        wr(`DTC_OFF_CONTROL, 8'h00);
        rdchk("a lower", `DTC_OFF_A_LOWER, 8'hff, 8'h03);
    endtask
    task automatic t_ext();
        i_pins.ext(1'b0, 1'b0);
        repeat (2) @(posedge pclk);
        rdchk("control", `DTC_OFF_CONTROL, 8'hff, 8'h0a);
        i_pins.ext(1'b1, 1'b1);
        repeat (2) @(posedge pclk);
        #1;
        chk("a request", {7'h0, ra}, 8'h00);
        wr(`DTC_OFF_CONTROL, 8'h05);
        i_pins.ext(1'b0, 1'b0);
        i_pins.ext(1'b1, 1'b1);
        repeat (2) @(posedge pclk);
        #1;
        chk("requests", {6'h0, rb, ra}, 8'h03);
        pulse_ack(4'b1100);
        chk("requests", {6'h0, rb, ra}, 8'h00);
        wr(`DTC_OFF_CONTROL, 8'h25);
        pulse_ack(4'b0001);
        rdchk("control", `DTC_OFF_CONTROL, 8'hff, 8'h05);
    endtask
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_map();
        t_reload16();
        t_reload8();
        t_var();
        t_split();
        t_gate();
        t_ext();
        wrap_up();
    end
    // Whole run needs well under two thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        wrap_up();
    end
endmodule
`default_nettype wire
